// ==== shared/ufcs_map.svh ====
`ifndef UFCS_MAP_SVH
`define UFCS_MAP_SVH

// Register addresses on the special-function-register bus
`define UFCS_ADDR_CTRL 8'h98
`define UFCS_ADDR_DATA 8'h99
`define UFCS_ADDR_MODE 8'hA9

// Control and status field positions
`define UFCS_OVR_BIT 7
`define UFCS_PERR_BIT 6
`define UFCS_THRE_BIT 5
`define UFCS_REN_BIT 4
`define UFCS_TBX_BIT 3
`define UFCS_RBX_BIT 2
`define UFCS_TI_BIT 1
`define UFCS_RI_BIT 0

// Frame mode field positions
`define UFCS_MCE_BIT 7
`define UFCS_PT_HI 6
`define UFCS_PT_LO 5
`define UFCS_PE_BIT 4
`define UFCS_DL_HI 3
`define UFCS_DL_LO 2
`define UFCS_XBE_BIT 1
`define UFCS_SBL_BIT 0

// Reset values
`define UFCS_CTRL_RESET 8'h20
`define UFCS_MODE_RESET 8'h0C

// Oversample tick counts (16 ticks per bit)
`define UFCS_TICK_MID 4'h7
`define UFCS_TICK_LAST 4'hF
`define UFCS_STOP1_LAST 6'h0F
`define UFCS_STOP15_LAST 6'h17
`define UFCS_STOP2_LAST 6'h1F

// Receive FIFO depth
`define UFCS_FIFO_DEPTH 2'h3

`endif

// ==== shared/ufcs_pkg.sv ====
package ufcs_pkg;

	typedef enum logic [4:0] {
		UFCS_IDLE = 5'b00001,
		UFCS_START = 5'b00010,
		UFCS_DATA = 5'b00100,
		UFCS_EXTRA = 5'b01000,
		UFCS_STOP = 5'b10000
	} ufcs_state_t;

	typedef enum logic [1:0] {
		UFCS_PAR_ODD = 2'h0,
		UFCS_PAR_EVEN = 2'h1,
		UFCS_PAR_MARK = 2'h2,
		UFCS_PAR_SPACE = 2'h3
	} ufcs_parity_t;

	// Keeps only the bits that the data length selects
	function automatic logic [7:0] ufcs_mask(input logic [7:0] d, input logic [1:0] len);
		logic [7:0] m;
		m = 8'hFF >> (3'h3 - {1'b0, len});
		return d & m;
	endfunction

	// Parity bit to send or expect for the given data
	function automatic logic ufcs_parity(input logic [7:0] d, input logic [1:0] len,
		input ufcs_parity_t pt);
		logic x;
		x = ^ufcs_mask(d, len);
		unique case (pt)
			UFCS_PAR_ODD: return ~x;
			UFCS_PAR_EVEN: return x;
			UFCS_PAR_MARK: return 1'b1;
			UFCS_PAR_SPACE: return 1'b0;
		endcase
	endfunction

endpackage

// ==== test/test_uart_frame_control_status.sv ====
`timescale 1ns/100ps
`default_nettype none

module test_uart_frame_control_status;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic tick_16x = 1'b0;
	logic [1:0] tk = 2'h0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic irq_enable = 1'b0;
	logic rx_pin;
	logic [7:0] sfr_rdata;
	logic tx_pin;
	logic irq_req;
	logic [31:0] lfsr = 32'h45D7FBCC;
	logic [63:0] u;
	int nu;
	int n_mismatch = 0;
	int num_checks = 0;
	logic [7:0] q[$];
	always #20 clock = ~clock;
	always @(posedge clock) begin
		tk <= tk + 2'h1;
		tick_16x <= (tk == 2'h3);
	end
	ufcs_top ufcs_top_inst (
		.clock(clock), .reset_n(reset_n), .tick_16x(tick_16x), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .irq_enable(irq_enable),
		.rx_pin(rx_pin), .sfr_rdata(sfr_rdata), .tx_pin(tx_pin), .irq_req(irq_req)
	);
	ufcs_node ufcs_node_inst (
		.clock(clock), .tick_16x(tick_16x), .tx_line(tx_pin), .rx_line(rx_pin)
	);
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk_line(input logic [11:0] e, input logic [11:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH tx frame expected %h seen %h", e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clock);
		sfr_wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clock);
		sfr_rd <= 1'b0;
		@(posedge clock);
		d = sfr_rdata;
	endtask
	task automatic add(input logic v, input int n);
		for (int i = 0; i < n; i++) begin
			u[nu] = v;
			nu++;
		end
	endtask
	// Frame model in half-bit units
	task automatic frame(input logic [7:0] d, input logic [7:0] m, input logic xb, input logic bad);
		int nd;
		logic p;
		nd = 5 + int'(m[3:2]);
		p = 1'b0;
		for (int i = 0; i < nd; i++)
			p ^= d[i];
		case (m[6:5])
			2'h0: p = ~p;
			2'h2: p = 1'b1;
			2'h3: p = 1'b0;
			default: ;
		endcase
		add(1'b0, 2);
		for (int i = 0; i < nd; i++)
			add(d[i], 2);
		if (m[4])
			add(p ^ bad, 2);
		else if (m[1])
			add(xb, 2);
		add(1'b1, m[0] ? (nd == 5 ? 3 : 4) : 2);
	endtask
	task automatic rx(input logic [7:0] d, input logic [7:0] m, input logic xb, input logic [1:0] f);
		nu = 0;
		u = '1;
		frame(d, m, xb, f[0]);
		if (f[1]) begin
			nu = nu - 2;
			add(1'b0, 2);
		end
		ufcs_node_inst.send(u, nu);
		repeat (8) @(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] v;
		logic [7:0] m;
		logic [11:0] e;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		rd(8'h98, v);
		chk("ctrl reset", 8'h20, v);
		rd(8'hA9, v);
		chk("mode reset", 8'h0C, v);
		wr(8'hA9, 8'h6B);
		rd(8'hA9, v);
		chk("mode", 8'h6B, v);
		wr(8'h5A, 8'hFF);
		rd(8'h5A, v);
		chk("unmapped", 8'h00, v);
		for (int i = 0; i < 8; i++) begin
			lfsr = nxt(lfsr);
			m = {1'b0, i[1:0], i[2], i[1:0], i[1], ~i[0]};
			irq_enable <= lfsr[5];
			wr(8'hA9, m);
			wr(8'h98, {4'h1, lfsr[9], 3'h0});
			nu = 0;
			u = '1;
			frame(lfsr[7:0], m, lfsr[9], 1'b0);
			frame(lfsr[17:10], m, lfsr[9], 1'b0);
			wr(8'h99, lfsr[7:0]);
			rd(8'h98, v);
			chk("holding empty", 8'h20, v & 8'h20);
			wr(8'h99, lfsr[17:10]);
			rd(8'h98, v);
			chk("holding full", 8'h00, v & 8'h20);
			for (int t = 0; t < 4000 && ufcs_node_inst.got.size() == 0; t++)
				@(posedge clock);
			if (ufcs_node_inst.got.size() == 0) begin
				n_mismatch++;
				$display("MISMATCH tx frame expected frame seen none");
				test_done();
			end
			for (int k = 0; k < 12; k++)
				e[k] = u[1 + 2 * k];
			chk_line(e, ufcs_node_inst.got.pop_front());
			// Second frame must end and the line idle long enough for the node to re-arm
			repeat (1600) @(posedge clock);
			rd(8'h98, v);
			chk("tx done", {4'h3, lfsr[9], 3'h2}, v & 8'hFB);
			chk("irq", {7'h00, lfsr[5]}, {7'h00, irq_req});
			wr(8'h98, 8'h10);
		end
		irq_enable <= 1'b1;
		wr(8'hA9, 8'h3C);
		wr(8'h98, 8'h00);
		rx(8'hA5, 8'h3C, 1'b0, 2'h0);
		rd(8'h98, v);
		chk("receiver off", 8'h20, v & 8'hFB);
		wr(8'h98, 8'h10);
		for (int j = 0; j < 4; j++) begin
			lfsr = nxt(lfsr);
			if (j < 3)
				q.push_back(lfsr[7:0]);
			rx(lfsr[7:0], 8'h3C, 1'b0, {1'b0, j == 0});
		end
		rd(8'h98, v);
		chk("overrun", 8'hF1, v & 8'hFB);
		chk("irq", 8'h01, {7'h00, irq_req});
		for (int j = 0; j < 3; j++) begin
			wr(8'h98, 8'hD0);
			rd(8'h98, v);
			chk("rx done", {7'h00, j < 2}, v & 8'h01);
			rd(8'h99, v);
			chk("rx data", q.pop_front(), v);
		end
		rd(8'h98, v);
		chk("parity error", 8'h40, v & 8'h40);
		wr(8'h98, 8'h10);
		rd(8'h98, v);
		chk("flags", 8'h30, v & 8'hFB);
		wr(8'hA9, 8'h8E);
		rx(8'h11, 8'h8E, 1'b1, 2'h2);
		rx(8'h22, 8'h8E, 1'b0, 2'h0);
		rd(8'h98, v);
		chk("address filter", 8'h30, v);
		rx(8'h33, 8'h8E, 1'b1, 2'h0);
		rd(8'h98, v);
		chk("address byte", 8'h31, v);
		rd(8'h99, v);
		chk("rx data", 8'h22, v);
		rd(8'h98, v);
		chk("rx extra", 8'h35, v);
		rd(8'h99, v);
		chk("rx data", 8'h33, v);
		test_done();
	end
endmodule // test_uart_frame_control_status
`default_nettype wire

// ==== test/ufcs_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ufcs_map.svh"

module ufcs_monitor (
	input wire logic clock, // Clock
	input wire logic reset_n, // Reset
	input wire logic tick_16x, // Tick
	input wire logic [7:0] sfr_addr, // Address
	input wire logic [7:0] sfr_wdata, // Write data
	input wire logic sfr_wr, // Write
	input wire logic sfr_rd, // Read
	input wire logic irq_enable, // Irq enable
	input wire logic rx_pin, // Rx line
	input wire logic [7:0] sfr_rdata, // Read data
	input wire logic tx_pin, // Tx line
	input wire logic irq_req // Irq
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	logic [7:0] lo_ticks;
	logic [5:0] hi_ticks;
	////////////////////////////////////////////////////////////////
	// Ticks spent low on the transmit line
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			lo_ticks <= 8'h00;
		else if (tx_pin)
			lo_ticks <= 8'h00;
		else if (tick_16x && lo_ticks != 8'hFF)
			lo_ticks <= lo_ticks + 8'h01;
	end
	// Ticks spent high, long enough means transmitter idle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			hi_ticks <= 6'h00;
		else if (!tx_pin)
			hi_ticks <= 6'h00;
		else if (tick_16x && hi_ticks != 6'h3F)
			hi_ticks <= hi_ticks + 6'h01;
	end
	////////////////////////////////////////////////////////////////
	sequence s_mode_wr; sfr_wr && sfr_addr == `UFCS_ADDR_MODE; endsequence
	sequence s_mode_rd; sfr_rd && !sfr_wr && sfr_addr == `UFCS_ADDR_MODE; endsequence
	sequence s_ctrl_wr; sfr_wr && sfr_addr == `UFCS_ADDR_CTRL; endsequence
	sequence s_ctrl_rd; sfr_rd && !sfr_wr && sfr_addr == `UFCS_ADDR_CTRL; endsequence
	a_reset_idle: assert property ($rose(reset_n) |-> tx_pin && !irq_req)
		else $error("outputs not idle after reset");
	a_irq_gate: assert property (!irq_enable |=> !irq_req)
		else $error("interrupt request without enable");
	a_start_hold: assert property ($fell(tx_pin) |-> !tx_pin [*8])
		else $error("start bit too short");
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data changed without read");
	a_mode_echo: assert property (s_mode_wr ##2 s_mode_rd |=>
		sfr_rdata == $past(sfr_wdata, 3))
		else $error("frame mode readback wrong");
	a_ctrl_echo: assert property (s_ctrl_wr ##2 s_ctrl_rd |=>
		(sfr_rdata & 8'h18) == ($past(sfr_wdata, 3) & 8'h18))
		else $error("control readback wrong");
	a_write_starts: assert property (sfr_wr && sfr_addr == `UFCS_ADDR_DATA
		&& hi_ticks >= 6'h22 |-> ##[1:6] !tx_pin)
		else $error("idle transmitter did not start");
	a_low_run: assert property (lo_ticks <= 8'hA1)
		else $error("transmit line low too long");
endmodule // ufcs_monitor

bind ufcs_top ufcs_monitor ufcs_monitor_inst (
	.clock(clock), .reset_n(reset_n), .tick_16x(tick_16x), .sfr_addr(sfr_addr),
	.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .irq_enable(irq_enable),
	.rx_pin(rx_pin), .sfr_rdata(sfr_rdata), .tx_pin(tx_pin), .irq_req(irq_req)
);
`default_nettype wire

// ==== test/ufcs_node.sv ====
`timescale 1ns/100ps
`default_nettype none

module ufcs_node (
	input wire logic clock, // System clock
	input wire logic tick_16x, // Bit-rate tick
	input wire logic tx_line, // From device
	output logic rx_line // Into device
);
	logic [11:0] got[$];
	logic [11:0] w;
	logic busy = 1'b0;
	int tc = 0;
	int idle = 200;
	initial rx_line = 1'b1;
	// Sends half-bit units, eight ticks each, then idles high
	task automatic send(input logic [63:0] u, input int nu);
		for (int k = 0; k < nu; k++) begin
			rx_line <= u[k];
			repeat (8) @(posedge clock iff tick_16x);
		end
		rx_line <= 1'b1;
	endtask
	// Arms after a gap longer than any frame, then samples twelve bits
	always @(posedge clock) begin
		if (tick_16x && busy) begin
			tc = tc + 1;
			if (tc % 16 == 12)
				w[tc / 16] = tx_line;
			if (tc == 188) begin
				busy = 1'b0;
				idle = 0;
				got.push_back(w);
			end
		end else if (tick_16x) begin
			if (!tx_line && idle >= 200) begin
				busy = 1'b1;
				tc = 0;
			end
			idle = tx_line ? idle + 1 : 0;
		end
	end
endmodule // ufcs_node
`default_nettype wire

// ==== verilog/ufcs_rx.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ufcs_map.svh"

module ufcs_rx (
	input wire logic clock, // System clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic tick_16x, // Oversample tick
	input wire logic rx_pin, // Serial input
	input wire logic rx_enable, // Receiver on
	input wire logic [1:0] data_len, // Data length select
	input wire logic parity_en, // Parity on
	input wire ufcs_pkg::ufcs_parity_t parity_type, // Parity type
	input wire logic extra_en, // Extra bit on
	output logic frame_done, // Pulse at stop sampling
	output logic [7:0] frame_data, // Received data
	output logic frame_extra, // Extra bit or first stop
	output logic frame_stop_ok, // Stop bit high
	output logic frame_perr // Parity mismatch
);

	ufcs_pkg::ufcs_state_t state_reg;
	logic [3:0] tick_reg;
	logic [2:0] idx_reg;
	logic [7:0] shift_reg;
	logic extra_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ufcs_pkg::UFCS_IDLE;
			tick_reg <= 4'h0;
			idx_reg <= 3'h0;
			shift_reg <= 8'h00;
			extra_reg <= 1'b0;
			frame_done <= 1'b0;
			frame_data <= 8'h00;
			frame_extra <= 1'b0;
			frame_stop_ok <= 1'b0;
			frame_perr <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			if (tick_16x) begin
				tick_reg <= tick_reg + 4'h1;
				unique case (state_reg)
					ufcs_pkg::UFCS_IDLE: begin
						if (rx_enable && !rx_pin) begin
							state_reg <= ufcs_pkg::UFCS_START;
							tick_reg <= 4'h0;
							shift_reg <= 8'h00;
						end
					end
					ufcs_pkg::UFCS_START: begin
						if (tick_reg == `UFCS_TICK_MID) begin
							tick_reg <= 4'h0;
							idx_reg <= 3'h0;
							// False start: line back high at mid-bit
							state_reg <= rx_pin ? ufcs_pkg::UFCS_IDLE
								: ufcs_pkg::UFCS_DATA;
						end
					end
					ufcs_pkg::UFCS_DATA: begin
						if (tick_reg == `UFCS_TICK_LAST) begin
							shift_reg[idx_reg] <= rx_pin;
							idx_reg <= idx_reg + 3'h1;
							if (idx_reg == {1'b1, data_len}) begin
								state_reg <= (parity_en || extra_en) ?
									ufcs_pkg::UFCS_EXTRA : ufcs_pkg::UFCS_STOP;
							end
						end
					end
					ufcs_pkg::UFCS_EXTRA: begin
						if (tick_reg == `UFCS_TICK_LAST) begin
							extra_reg <= rx_pin;
							state_reg <= ufcs_pkg::UFCS_STOP;
						end
					end
					ufcs_pkg::UFCS_STOP: begin
						if (tick_reg == `UFCS_TICK_LAST) begin
							frame_done <= 1'b1;
							frame_stop_ok <= rx_pin;
							frame_data <= ufcs_pkg::ufcs_mask(shift_reg, data_len);
							frame_extra <= extra_en ? extra_reg : rx_pin;
							frame_perr <= parity_en && (extra_reg != ufcs_pkg::ufcs_parity(
								shift_reg, data_len, parity_type));
							state_reg <= ufcs_pkg::UFCS_IDLE;
						end
					end
				endcase
			end
		end
	end

endmodule // ufcs_rx

`default_nettype wire

// ==== verilog/ufcs_top.sv ====
// Functional notes
// - Overrun flag bit 7 sets when a character arrives with FIFO full and no data buffer read; char dropped.
// - With parity on, parity error bit 6 sets when oldest FIFO byte mismatches.
// - Parity error flag is cleared only by software writing zero.
// - Bit 5 reads 1 when transmit holding register is empty.
// - Receive enable bit 4 gates reception; stored bytes stay readable.
// - With extra bit on and parity off, bit 3 is sent as extra bit.
// - Bit 2 holds received extra bit, or first stop bit when extra is off.
// - Transmit-done bit 1 sets at stop-bit start; requests interrupt; software clears.
// - Receive-done bit 0 sets at stop sampling of an accepted byte.
// - Receive-done raises a port interrupt request when enabled.
// - Receive-done stays set while bytes wait; clear works once only buffer remains.
// - Multiprocessor mode needs received extra bit 1 for receive-done.
// - Parity type bits 6:5 select odd, even, mark, space.
// - Parity enable bit 4 turns on parity generation and checking.
// - Data length bits 3:2 select five to eight data bits.
// - Extra bit enable bit 1 appends one extra bit after the data unless parity is on.
// - Stop length: one bit, or two bits (1.5 for five-bit data).
// - Frame: low start, data LSB first, optional extra, high stop.
// - Byte enters three-entry FIFO only with space and high stop bit.
// - Data buffer read returns oldest byte; next byte follows at once.
// - Data buffer write loads holding register, clears empty, starts sending.
`timescale 1ns/100ps
`default_nettype none
`include "ufcs_map.svh"

module ufcs_top (
	input wire logic clock, // System clock, 25 MHz
	input wire logic reset_n, // Asynchronous reset
	input wire logic tick_16x, // Bit-rate tick, 16 per bit
	input wire logic [7:0] sfr_addr, // Register address
	input wire logic [7:0] sfr_wdata, // Write data
	input wire logic sfr_wr, // Write strobe
	input wire logic sfr_rd, // Read strobe
	input wire logic irq_enable, // Port interrupt enable
	input wire logic rx_pin, // Serial receive line
	output logic [7:0] sfr_rdata, // Read data, one cycle after strobe
	output logic tx_pin, // Serial transmit line
	output logic irq_req // Port interrupt request
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0] mode_reg;
	logic ovr_reg;
	logic perr_reg;
	logic thre_reg;
	logic ren_reg;
	logic tbx_reg;
	logic ti_reg;
	logic ri_reg;

	logic [7:0] fifo_data_reg [0:2];
	logic fifo_extra_reg [0:2];
	logic fifo_perr_reg [0:2];
	logic [1:0] fifo_count_reg;

	logic [7:0] hold_reg;
	ufcs_pkg::ufcs_state_t tx_state_reg;
	logic [5:0] tx_tick_reg;
	logic [2:0] tx_idx_reg;
	logic [7:0] tx_shift_reg;
	logic tx_bit;
	logic [5:0] stop_last;

	logic rx_done;
	logic [7:0] rx_data;
	logic rx_extra;
	logic rx_stop_ok;
	logic rx_perr;

	logic mce;
	ufcs_pkg::ufcs_parity_t ptype;
	logic pe;
	logic [1:0] dlen;
	logic xbe;
	logic sbl;

	logic wr_ctrl;
	logic wr_mode;
	logic wr_data;
	logic rd_data;
	logic pop;
	logic accept;
	logic overrun;
	logic [1:0] count_after;
	logic head_new;
	logic head_perr;

	////////////////////////////////////////////////////////////////////////////
	// Field decode

	assign mce = mode_reg[`UFCS_MCE_BIT];
	assign ptype = ufcs_pkg::ufcs_parity_t'(mode_reg[`UFCS_PT_HI:`UFCS_PT_LO]);
	assign pe = mode_reg[`UFCS_PE_BIT];
	assign dlen = mode_reg[`UFCS_DL_HI:`UFCS_DL_LO];
	assign xbe = mode_reg[`UFCS_XBE_BIT];
	assign sbl = mode_reg[`UFCS_SBL_BIT];

	assign wr_ctrl = sfr_wr && (sfr_addr == `UFCS_ADDR_CTRL);
	assign wr_mode = sfr_wr && (sfr_addr == `UFCS_ADDR_MODE);
	assign wr_data = sfr_wr && (sfr_addr == `UFCS_ADDR_DATA);
	assign rd_data = sfr_rd && (sfr_addr == `UFCS_ADDR_DATA);

	////////////////////////////////////////////////////////////////////////////
	// Receiver

	ufcs_rx u_rx (
		.clock(clock),
		.reset_n(reset_n),
		.tick_16x(tick_16x),
		.rx_pin(rx_pin),
		.rx_enable(ren_reg),
		.data_len(dlen),
		.parity_en(pe),
		.parity_type(ptype),
		.extra_en(xbe),
		.frame_done(rx_done),
		.frame_data(rx_data),
		.frame_extra(rx_extra),
		.frame_stop_ok(rx_stop_ok),
		.frame_perr(rx_perr)
	);

	////////////////////////////////////////////////////////////////////////////
	// Receive FIFO; entry 0 is the data buffer seen by software

	assign pop = rd_data && (fifo_count_reg != 2'h0);
	assign overrun = rx_done && rx_stop_ok
		&& (fifo_count_reg == `UFCS_FIFO_DEPTH) && !pop;
	assign accept = rx_done && rx_stop_ok && !overrun;
	assign count_after = fifo_count_reg + {1'b0, accept} - {1'b0, pop};

	// A byte becomes oldest when pushed into an empty or drained FIFO, or exposed by a pop
	assign head_new = (accept && ((fifo_count_reg == 2'h0) || (pop && (fifo_count_reg == 2'h1))))
		|| (pop && (fifo_count_reg > 2'h1));
	assign head_perr = (pop && (fifo_count_reg > 2'h1))
		? fifo_perr_reg[1] : rx_perr;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fifo_count_reg <= 2'h0;
			for (int i = 0; i < 3; i++) begin
				fifo_data_reg[i] <= 8'h00;
				fifo_extra_reg[i] <= 1'b0;
				fifo_perr_reg[i] <= 1'b0;
			end
		end else begin
			fifo_count_reg <= count_after;
			if (pop) begin
				fifo_data_reg[0] <= fifo_data_reg[1];
				fifo_data_reg[1] <= fifo_data_reg[2];
				fifo_extra_reg[0] <= fifo_extra_reg[1];
				fifo_extra_reg[1] <= fifo_extra_reg[2];
				fifo_perr_reg[0] <= fifo_perr_reg[1];
				fifo_perr_reg[1] <= fifo_perr_reg[2];
			end
			if (accept) begin
				fifo_data_reg[count_after - 2'h1] <= rx_data;
				fifo_extra_reg[count_after - 2'h1] <= rx_extra;
				fifo_perr_reg[count_after - 2'h1] <= rx_perr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control and status flags; a hardware set wins over a software clear

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ovr_reg <= 1'b0;
			ren_reg <= 1'b0;
			tbx_reg <= 1'b0;
		end else begin
			if (overrun) begin
				ovr_reg <= 1'b1;
			end else if (wr_ctrl) begin
				ovr_reg <= sfr_wdata[`UFCS_OVR_BIT];
			end
			if (wr_ctrl) begin
				ren_reg <= sfr_wdata[`UFCS_REN_BIT];
				tbx_reg <= sfr_wdata[`UFCS_TBX_BIT];
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			perr_reg <= 1'b0;
		end else if (pe && head_new && head_perr) begin
			perr_reg <= 1'b1;
		end else if (wr_ctrl) begin
			perr_reg <= sfr_wdata[`UFCS_PERR_BIT];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ri_reg <= 1'b0;
		end else if (accept && (!mce || (xbe && rx_extra))) begin
			ri_reg <= 1'b1;
		end else if (wr_ctrl && sfr_wdata[`UFCS_RI_BIT]) begin
			ri_reg <= 1'b1;
		end else if (wr_ctrl && (count_after <= 2'h1)) begin
			ri_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ti_reg <= 1'b0;
		end else if ((tx_state_reg == ufcs_pkg::UFCS_EXTRA
			|| tx_state_reg == ufcs_pkg::UFCS_DATA) && tx_bit_end()
			&& (tx_state_reg == ufcs_pkg::UFCS_EXTRA || !(pe || xbe))
			&& (tx_state_reg == ufcs_pkg::UFCS_EXTRA
			|| tx_idx_reg == {1'b1, dlen})) begin
			ti_reg <= 1'b1;
		end else if (wr_ctrl) begin
			ti_reg <= sfr_wdata[`UFCS_TI_BIT];
		end
	end

	// Port interrupt request from either completion flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= irq_enable && (ri_reg || ti_reg);
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode_reg <= `UFCS_MODE_RESET;
		end else if (wr_mode) begin
			mode_reg <= sfr_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read path

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			unique case (sfr_addr)
				`UFCS_ADDR_CTRL: sfr_rdata <= {ovr_reg, perr_reg, thre_reg, ren_reg,
					tbx_reg, fifo_extra_reg[0], ti_reg, ri_reg};
				`UFCS_ADDR_MODE: sfr_rdata <= mode_reg;
				`UFCS_ADDR_DATA: sfr_rdata <= fifo_data_reg[0];
				default: sfr_rdata <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmitter

	// Last tick of the current bit
	function automatic logic tx_bit_end();
		return tick_16x && (tx_tick_reg == {2'b00, `UFCS_TICK_LAST});
	endfunction

	always_comb begin
		if (!sbl) begin
			stop_last = `UFCS_STOP1_LAST;
		end else if (dlen == 2'h0) begin
			stop_last = `UFCS_STOP15_LAST;
		end else begin
			stop_last = `UFCS_STOP2_LAST;
		end
	end

	// Holding register and its empty flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			hold_reg <= 8'h00;
			thre_reg <= 1'b1;
		end else if (wr_data) begin
			hold_reg <= sfr_wdata;
			thre_reg <= 1'b0;
		end else if (tx_state_reg == ufcs_pkg::UFCS_IDLE && !thre_reg) begin
			thre_reg <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_state_reg <= ufcs_pkg::UFCS_IDLE;
			tx_tick_reg <= 6'h00;
			tx_idx_reg <= 3'h0;
			tx_shift_reg <= 8'h00;
		end else begin
			if (tick_16x) begin
				tx_tick_reg <= tx_tick_reg + 6'h01;
			end
			unique case (tx_state_reg)
				ufcs_pkg::UFCS_IDLE: begin
					if (!thre_reg && !wr_data) begin
						tx_shift_reg <= ufcs_pkg::ufcs_mask(hold_reg, dlen);
						tx_tick_reg <= 6'h00;
						tx_state_reg <= ufcs_pkg::UFCS_START;
					end
				end
				ufcs_pkg::UFCS_START: begin
					if (tx_bit_end()) begin
						tx_tick_reg <= 6'h00;
						tx_idx_reg <= 3'h0;
						tx_state_reg <= ufcs_pkg::UFCS_DATA;
					end
				end
				ufcs_pkg::UFCS_DATA: begin
					if (tx_bit_end()) begin
						tx_tick_reg <= 6'h00;
						tx_idx_reg <= tx_idx_reg + 3'h1;
						if (tx_idx_reg == {1'b1, dlen}) begin
							tx_state_reg <= (pe || xbe) ? ufcs_pkg::UFCS_EXTRA
								: ufcs_pkg::UFCS_STOP;
						end
					end
				end
				ufcs_pkg::UFCS_EXTRA: begin
					if (tx_bit_end()) begin
						tx_tick_reg <= 6'h00;
						tx_state_reg <= ufcs_pkg::UFCS_STOP;
					end
				end
				ufcs_pkg::UFCS_STOP: begin
					if (tick_16x && tx_tick_reg == stop_last) begin
						tx_tick_reg <= 6'h00;
						tx_state_reg <= ufcs_pkg::UFCS_IDLE;
					end
				end
			endcase
		end
	end

	// Line level for the current bit
	always_comb begin
		unique case (tx_state_reg)
			ufcs_pkg::UFCS_START: tx_bit = 1'b0;
			ufcs_pkg::UFCS_DATA: tx_bit = tx_shift_reg[tx_idx_reg];
			ufcs_pkg::UFCS_EXTRA: tx_bit = pe
				? ufcs_pkg::ufcs_parity(tx_shift_reg, dlen, ptype)
				: tbx_reg;
			default: tx_bit = 1'b1;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_pin <= 1'b1;
		end else begin
			tx_pin <= tx_bit;
		end
	end

endmodule // ufcs_top

`default_nettype wire
